// ---- inc/tse_pkg.sv ----
// tse_pkg: constants and types of the two-wire serial eeprom target
// assumes: 250 MHz system clock, pins sampled through two flip-flops
package tse_pkg;

    // ************************************************
    // array geometry
    // ************************************************
    localparam int ADDR_W     = 14;
    localparam int PAGE_W     = 6;
    localparam int BASE_W     = ADDR_W - PAGE_W;
    localparam int MEM_BYTES  = 16384;
    localparam int PAGE_BYTES = 64;

    // ************************************************
    // bus framing
    // ************************************************
    localparam logic [3:0] DEV_CODE  = 4'hA;
    localparam logic [3:0] BIT_LAST  = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [6:0] PAGE_END  = 7'h40;
    localparam logic [5:0] PAGE_TOP  = 6'h3F;

    // ************************************************
    // pin sampling vector
    // ************************************************
    localparam int PIN_W     = 6;
    localparam int PIN_SCL   = 0;
    localparam int PIN_SDA   = 1;
    localparam int PIN_STRAP = 2;
    localparam int PIN_WP    = 5;

    // ************************************************
    // timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int WRITE_TIME_NS = 5000000;
    localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int WAIT_W        = 21;

    // ************************************************
    // staging fifo
    // ************************************************
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_W     = PAGE_W + 8;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_DEV   = 3'h1,
        ST_AHI   = 3'h3,
        ST_ALO   = 3'h2,
        ST_WDAT  = 3'h6,
        ST_READ  = 3'h7,
        ST_SKIP  = 3'h4
    } tse_state_type;

endpackage

// ---- rtl/tse_fifo.sv ----
// tse_fifo: small valid/ready fifo for received write bytes
// assumes: one clock, asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none

module tse_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int PW = $clog2(DEPTH);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [PW:0]   CNT_FULL = (PW + 1)'(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0]   count;
    } tse_fifo_regs_type;

    tse_fifo_regs_type r;
    tse_fifo_regs_type next_r;
    logic [WIDTH-1:0]  store [DEPTH];
    logic              put;
    logic              get;

    assign in_ready  = r.count != CNT_FULL;
    assign out_valid = r.count != '0;
    assign out_data  = store[r.rd_ptr];
    assign put       = in_valid & in_ready;
    assign get       = out_valid & out_ready;

    always_comb begin
        next_r = r;
        if (put) begin
            next_r.wr_ptr = (r.wr_ptr == PTR_LAST) ? '0 : r.wr_ptr + 1'b1;
        end
        if (get) begin
            next_r.rd_ptr = (r.rd_ptr == PTR_LAST) ? '0 : r.rd_ptr + 1'b1;
        end
        if (put & !get) begin
            next_r.count = r.count + 1'b1;
        end else if (get & !put) begin
            next_r.count = r.count - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (put) begin
            store[r.wr_ptr] <= in_data;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/tse_eeprom.sv ----
// tse_eeprom: two-wire serial eeprom target with 16384 byte array
// assumes: scl, sda and straps are asynchronous pins; sda is open drain,
// resolved outside from sda_oe; clk_sys is far faster than scl
`timescale 1ns/1ns
`default_nettype none

module tse_eeprom #(
    parameter int WRITE_CYCLES = tse_pkg::WRITE_CYCLES
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // two-wire bus pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // straps and protection
    input  wire logic strap_select_bit0,
    input  wire logic strap_select_bit1,
    input  wire logic strap_select_bit2,
    input  wire logic write_protect,
    // status
    output logic      standby,
    output logic      write_busy
);

    localparam logic [tse_pkg::WAIT_W-1:0] WAIT_LAST =
        tse_pkg::WAIT_W'(WRITE_CYCLES - tse_pkg::PAGE_BYTES - 2);

    typedef struct packed {
        logic [tse_pkg::PIN_W-1:0]  pin_s1;
        logic [tse_pkg::PIN_W-1:0]  pin_s2;
        logic                       scl_d;
        logic                       sda_d;
        tse_pkg::tse_state_type     state;
        logic [3:0]                 bitcnt;
        logic                       ack_slot;
        logic                       go_on;
        logic [7:0]                 shreg;
        logic [5:0]                 addr_hi;
        logic [tse_pkg::ADDR_W-1:0] addr;
        logic [tse_pkg::BASE_W-1:0] page_base;
        logic [tse_pkg::PAGE_BYTES-1:0] mask;
        logic                       busy;
        logic                       commit_run;
        logic [6:0]                 idx;
        logic [tse_pkg::WAIT_W-1:0] wait_cnt;
        logic                       sda_oe;
        logic                       sda_out;
        logic                       standby;
    } tse_regs_type;

    // ************************************************
    // storage and wiring
    // ************************************************
    tse_regs_type                  r;
    tse_regs_type                  next_r;
    logic [7:0]                    mem  [tse_pkg::MEM_BYTES];
    logic [7:0]                    page [tse_pkg::PAGE_BYTES];
    logic [7:0]                    rd_data;
    logic                          scl;
    logic                          sda;
    logic                          rise;
    logic                          fall;
    logic                          start_cond;
    logic                          stop_cond;
    logic                          addr_match;
    logic                          push;
    logic                          fifo_in_ready;
    logic                          fifo_out_valid;
    logic                          drain_ready;
    logic                          drain_take;
    logic [tse_pkg::FIFO_W-1:0]    fifo_out_data;
    logic                          mem_we;
    logic [tse_pkg::ADDR_W-1:0]    mem_waddr;

    // ************************************************
    // bus conditions from the second sampling stage
    // ************************************************
    assign scl  = r.pin_s2[tse_pkg::PIN_SCL];
    assign sda  = r.pin_s2[tse_pkg::PIN_SDA];
    assign rise = scl & !r.scl_d;
    assign fall = !scl & r.scl_d;
    assign start_cond = scl & r.scl_d & r.sda_d & !sda;
    assign stop_cond  = scl & r.scl_d & !r.sda_d & sda;

    assign addr_match = (r.shreg[7:4] == tse_pkg::DEV_CODE)
                      && (r.shreg[3:1] == r.pin_s2[tse_pkg::PIN_STRAP +: 3]);

    // ************************************************
    // staging fifo for written bytes
    // ************************************************
    // drain stalls while the page is being programmed
    assign drain_ready = !r.commit_run;
    assign drain_take  = fifo_out_valid & drain_ready;

    tse_fifo #(
        .WIDTH (tse_pkg::FIFO_W),
        .DEPTH (tse_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   ({r.addr[tse_pkg::PAGE_W-1:0], r.shreg}),
        .out_valid (fifo_out_valid),
        .out_ready (drain_ready),
        .out_data  (fifo_out_data)
    );

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        next_r = r;
        push   = 1'b0;
        mem_we = 1'b0;
        next_r.pin_s1 = {write_protect, strap_select_bit2, strap_select_bit1,
                         strap_select_bit0, sda_in, scl_in};
        next_r.pin_s2 = r.pin_s1;
        next_r.scl_d  = scl;
        next_r.sda_d  = sda;

        if (drain_take) begin
            next_r.mask[fifo_out_data[tse_pkg::FIFO_W-1:8]] = 1'b1;
        end

        // one pass over all 64 page slots, writing each marked slot while write_protect is low
        if (r.busy) begin
            if (r.commit_run) begin
                mem_we = r.mask[r.idx[5:0]] & !r.pin_s2[tse_pkg::PIN_WP];
                if (r.idx[5:0] == tse_pkg::PAGE_TOP) begin
                    next_r.commit_run = 1'b0;
                    next_r.idx        = tse_pkg::PAGE_END;
                end else begin
                    next_r.idx = r.idx + 1'b1;
                end
            end else if (r.idx == tse_pkg::PAGE_END) begin
                if (r.wait_cnt == WAIT_LAST) begin
                    next_r.busy     = 1'b0;
                    next_r.idx      = '0;
                    next_r.wait_cnt = '0;
                    next_r.mask     = '0;
                end else begin
                    next_r.wait_cnt = r.wait_cnt + 1'b1;
                end
            end else if (!fifo_out_valid) begin
                next_r.commit_run = 1'b1;
            end
        end

        if (start_cond) begin
            next_r.state    = tse_pkg::ST_DEV;
            next_r.bitcnt   = '0;
            next_r.ack_slot = 1'b0;
            next_r.sda_oe   = 1'b0;
            if (!r.busy) begin
                next_r.mask = '0;
            end
        end else if (stop_cond) begin
            next_r.state    = tse_pkg::ST_IDLE;
            next_r.ack_slot = 1'b0;
            next_r.sda_oe   = 1'b0;
            if (!r.busy && (r.mask != '0 || fifo_out_valid)) begin
                next_r.busy = 1'b1;
            end
        end else if (r.state != tse_pkg::ST_IDLE && r.state != tse_pkg::ST_SKIP) begin
            if (rise) begin
                if (r.ack_slot) begin
                    if (!r.sda_oe) begin
                        next_r.go_on = !sda;
                    end
                end else if (r.state != tse_pkg::ST_READ) begin
                    next_r.shreg  = {r.shreg[6:0], sda};
                    next_r.bitcnt = r.bitcnt + 1'b1;
                end
            end else if (fall) begin
                if (r.ack_slot) begin
                    next_r.ack_slot = 1'b0;
                    next_r.sda_oe   = 1'b0;
                    next_r.bitcnt   = '0;
                    if (r.state == tse_pkg::ST_READ) begin
                        if (r.go_on) begin
                            next_r.sda_oe = !rd_data[7];
                            next_r.shreg  = {rd_data[6:0], 1'b0};
                            next_r.bitcnt = tse_pkg::BIT_FIRST;
                            next_r.addr   = r.addr + 1'b1;
                        end else begin
                            next_r.state = tse_pkg::ST_SKIP;
                        end
                    end
                end else if (r.bitcnt == tse_pkg::BIT_LAST) begin
                    if (r.state == tse_pkg::ST_READ) begin
                        next_r.sda_oe   = 1'b0;
                        next_r.ack_slot = 1'b1;
                        next_r.go_on    = 1'b0;
                    end else begin
                        next_r.sda_oe   = 1'b1;
                        next_r.ack_slot = 1'b1;
                        next_r.go_on    = 1'b1;
                        case (r.state)
                            tse_pkg::ST_DEV: begin
                                if (addr_match && !r.busy) begin
                                    if (r.shreg[0]) begin
                                        next_r.state = tse_pkg::ST_READ;
                                    end else begin
                                        next_r.state = tse_pkg::ST_AHI;
                                    end
                                end else begin
                                    next_r.sda_oe   = 1'b0;
                                    next_r.ack_slot = 1'b0;
                                    next_r.state    = tse_pkg::ST_SKIP;
                                end
                            end
                            tse_pkg::ST_AHI: begin
                                next_r.addr_hi = r.shreg[5:0];
                                next_r.state   = tse_pkg::ST_ALO;
                            end
                            tse_pkg::ST_ALO: begin
                                next_r.addr      = {r.addr_hi, r.shreg};
                                next_r.page_base = {r.addr_hi, r.shreg[7:6]};
                                next_r.state     = tse_pkg::ST_WDAT;
                            end
                            tse_pkg::ST_WDAT: begin
                                if (fifo_in_ready) begin
                                    push = 1'b1;
                                    next_r.addr[tse_pkg::PAGE_W-1:0] =
                                        r.addr[tse_pkg::PAGE_W-1:0] + 1'b1;
                                end else begin
                                    next_r.sda_oe   = 1'b0;
                                    next_r.ack_slot = 1'b0;
                                    next_r.state    = tse_pkg::ST_SKIP;
                                end
                            end
                            default: begin
                                next_r.sda_oe   = 1'b0;
                                next_r.ack_slot = 1'b0;
                                next_r.state    = tse_pkg::ST_SKIP;
                            end
                        endcase
                    end
                end else if (r.state == tse_pkg::ST_READ) begin
                    next_r.sda_oe = !r.shreg[7];
                    next_r.shreg  = {r.shreg[6:0], 1'b0};
                    next_r.bitcnt = r.bitcnt + 1'b1;
                end
            end
        end

        next_r.standby = (next_r.state == tse_pkg::ST_IDLE
                          || next_r.state == tse_pkg::ST_SKIP) && !next_r.busy;
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************
    // page buffer and array
    // ************************************************
    // 16384 bytes, fourteen-bit location
    assign mem_waddr = {r.page_base, r.idx[5:0]};

    always_ff @(posedge clk_sys) begin
        if (drain_take) begin
            page[fifo_out_data[tse_pkg::FIFO_W-1:8]] <= fifo_out_data[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[mem_waddr] <= page[r.idx[5:0]];
        end
        rd_data <= mem[r.addr];
    end

    // ************************************************
    // outputs
    // ************************************************
    // only sda is ever driven
    assign sda_out    = r.sda_out;
    assign sda_oe     = r.sda_oe;
    assign standby    = r.standby;
    assign write_busy = r.busy;

endmodule

`default_nettype wire

// ---- tb/tse_chk.sv ----
// tse_chk: pin-level checks of the two-wire eeprom target
// assumes: bound into tse_eeprom, sda_in is the resolved wire
`timescale 1ns/1ns
`default_nettype none
module tse_chk #(parameter int WRITE_CYCLES = 1250000) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // straps and status
    input wire logic strap_select_bit0,
    input wire logic strap_select_bit1,
    input wire logic strap_select_bit2,
    input wire logic write_protect,
    input wire logic standby,
    input wire logic write_busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    int busy_cnt;
    // length of the running write cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= write_busy ? busy_cnt + 1 : 0;
        end
    end
    a_open_drain: assert property (sda_out == 1'b0)
        else $error("sda_out driven high");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda_oe moved while scl high");
    a_drive_in_low: assert property ($rose(sda_oe) |-> !scl_in [*6])
        else $error("sda pulled too late in low phase");
    a_busy_at_stop: assert property ($rose(write_busy) |-> scl_in && sda_in)
        else $error("write cycle began without a stop");
    a_busy_silent: assert property (write_busy |-> !sda_oe && !standby)
        else $error("target active during write cycle");
    a_busy_bound: assert property (busy_cnt <= WRITE_CYCLES)
        else $error("write cycle too long");
    a_idle_after_write: assert property ($fell(write_busy) |-> ##[0:2] standby)
        else $error("no standby after write cycle");
    a_start_wakes: assert property (
        scl_in && $fell(sda_in) && !write_busy |-> ##[2:6] !standby)
        else $error("start not taken");
    a_stop_ends: assert property (
        scl_in && $rose(sda_in) |-> ##[2:8] (standby || write_busy))
        else $error("stop did not end transaction");
    a_quiet_standby: assert property (standby |-> !sda_oe)
        else $error("sda pulled in standby");
    c_write: cover property ($rose(write_busy));
    c_write_done: cover property ($fell(write_busy));
    c_ack: cover property ($rose(sda_oe));
endmodule
bind tse_eeprom tse_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_select_bit0(strap_select_bit0),
    .strap_select_bit1(strap_select_bit1), .strap_select_bit2(strap_select_bit2),
    .write_protect(write_protect), .standby(standby), .write_busy(write_busy));
`default_nettype wire

// ---- tb/tse_ctl_model.sv ----
// tse_ctl_model: behavioural two-wire bus controller
// assumes: sda pulled up outside; scl rests high between frames
`timescale 1ns/1ns
`default_nettype none
module tse_ctl_model (
    // clock
    input wire logic clk_sys,
    // bus wires
    input wire logic sda_in,
    output logic     scl,
    output logic     sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one scl pulse per bit, sda moved only while low
    task automatic clock_bit(input logic pull, output logic seen);
        repeat (4) @(posedge clk_sys);
        sda_low <= pull;
        // 16 clk_sys per bit: 64 ns link period
        repeat (6) @(posedge clk_sys);
        scl <= 1'b1;
        repeat (6) @(posedge clk_sys);
        seen = sda_in;
        scl <= 1'b0;
    endtask
    task automatic condition(input logic first, input logic last);
        repeat (4) @(posedge clk_sys);
        sda_low <= first;
        repeat (8) @(posedge clk_sys);
        scl <= 1'b1;
        repeat (12) @(posedge clk_sys);
        sda_low <= last;
        repeat (12) @(posedge clk_sys);
    endtask
    task automatic start();
        condition(1'b0, 1'b1);
        scl <= 1'b0;
    endtask
    task automatic stop();
        condition(1'b1, 1'b0);
    endtask
    // msb first, ninth clock left to the target
    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(!b[i], s);
        end
        clock_bit(1'b0, s);
        acked = !s;
    endtask
    // ack for more, high on the last byte
    task automatic recv_byte(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b0, b[i]);
        end
        clock_bit(more, s);
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// tb: self-checking bench of the two-wire eeprom target
// assumes: controller model on the bus, pull-up resolved here
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam logic [7:0] DEV_W = 8'hAA;
    localparam logic [7:0] DEV_R = 8'hAB;
    logic       clk_sys = 1'b0;
    logic       resetn = 1'b0;
    logic       write_protect = 1'b0;
    logic [2:0] straps = 3'h5;
    logic       scl;
    logic       sda_low;
    logic       sda_out;
    logic       sda_oe;
    logic       standby;
    logic       write_busy;
    int         fails = 0;
    int         compares = 0;
    int         cycles = 0;
    wire logic  sda = !(sda_oe || sda_low);
    tse_eeprom #(.WRITE_CYCLES(2000)) uut (
        .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .strap_select_bit0(straps[0]),
        .strap_select_bit1(straps[1]), .strap_select_bit2(straps[2]),
        .write_protect(write_protect), .standby(standby), .write_busy(write_busy));
    tse_ctl_model ctl (.clk_sys(clk_sys), .sda_in(sda), .scl(scl), .sda_low(sda_low));
    always #2 clk_sys = ~clk_sys;
    task automatic wrap_up();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 80000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic set_loc(input logic [13:0] loc);
        logic a0, a1, a2;
        ctl.start();
        ctl.send_byte(DEV_W, a0);
        ctl.send_byte({2'h3, loc[13:8]}, a1);
        ctl.send_byte(loc[7:0], a2);
        check("loc ack", {13'h0, a0, a1, a2}, 16'h0007);
    endtask
    task automatic read_seq(input logic [7:0] exp [$]);
        logic       a;
        logic [7:0] b;
        ctl.start();
        ctl.send_byte(DEV_R, a);
        check("read ack", a, 1'b1);
        foreach (exp[i]) begin
            ctl.recv_byte(i < exp.size() - 1, b);
            check("read data", b, exp[i]);
        end
        ctl.stop();
        check("released", {sda_oe, standby}, 2'b01);
    endtask
    task automatic write_bytes(input logic [13:0] loc, input logic [7:0] d [$]);
        logic a;
        set_loc(loc);
        foreach (d[i]) begin
            ctl.send_byte(d[i], a);
            check("data ack", a, 1'b1);
        end
        ctl.stop();
        check("busy", {write_busy, standby}, 2'b10);
        ctl.start();
        ctl.send_byte(DEV_W, a);
        check("poll busy", a, 1'b0);
        ctl.stop();
        for (int n = 0; n < 3000 && write_busy === 1'b1; n++) begin
            @(posedge clk_sys);
        end
        repeat (2) @(posedge clk_sys);
        check("done", {write_busy, standby}, 2'b01);
        ctl.start();
        ctl.send_byte(DEV_W, a);
        check("poll done", a, 1'b1);
        ctl.stop();
    endtask
    task automatic s_filter();
        logic       a;
        logic [7:0] bad [3] = '{8'hA2, 8'hA8, 8'hBA};
        foreach (bad[i]) begin
            ctl.start();
            ctl.send_byte(bad[i], a);
            check("foreign addr", a, 1'b0);
            ctl.stop();
            check("ignored", standby, 1'b1);
        end
        straps <= 3'h0;
        ctl.start();
        ctl.send_byte(8'hA0, a);
        check("strap zero", a, 1'b1);
        ctl.stop();
        straps <= 3'h5;
    endtask
    task automatic s_page();
        write_bytes(14'h3FFF, '{8'hA5, 8'h5A, 8'h3C});
        write_bytes(14'h0000, '{8'hC3});
        set_loc(14'h3FFF);
        read_seq('{8'hA5, 8'hC3});
        set_loc(14'h3FC0);
        read_seq('{8'h5A});
        read_seq('{8'h3C});
    endtask
    task automatic s_overrun();
        logic [7:0] q [$];
        for (int i = 0; i < 65; i++) begin
            q.push_back(i == 64 ? 8'hEE : 8'(i));
        end
        write_bytes(14'h0080, q);
        set_loc(14'h0080);
        read_seq('{8'hEE, 8'h01});
    endtask
    task automatic s_abort();
        logic a;
        set_loc(14'h0000);
        ctl.send_byte(8'h77, a);
        check("abort ack", a, 1'b1);
        set_loc(14'h0000);
        check("no commit", write_busy, 1'b0);
        read_seq('{8'hC3});
    endtask
    task automatic s_protect();
        write_protect <= 1'b1;
        write_bytes(14'h0000, '{8'h99});
        write_protect <= 1'b0;
        set_loc(14'h0000);
        read_seq('{8'hC3});
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check("rest", {sda_oe, standby, write_busy}, 3'b010);
        s_filter();
        s_page();
        s_overrun();
        s_abort();
        s_protect();
        wrap_up();
    end
endmodule
`default_nettype wire
